// File: core/lsmi_regs.vh
`ifndef LSMI_REGS_VH
`define LSMI_REGS_VH

// register offsets on the internal register port
`define LSMI_FAN_MASK_ADDR 8'h1a
`define LSMI_MISC_MASK_ADDR 8'h1b
`define LSMI_GPIO_LO_MASK_ADDR 8'h1c
`define LSMI_GPIO_HI_MASK_ADDR 8'h1d
`define LSMI_TEMP_OFFSET_ADDR 8'h1e
`define LSMI_TEMP_VALUE_ADDR 8'h1f
`define LSMI_VOLT_STATUS_ADDR 8'h20
`define LSMI_AIN_STATUS_ADDR 8'h21
`define LSMI_FAN_STATUS_ADDR 8'h22

// reset value of every register in this block
`define LSMI_RESET_VALUE 8'h00
// value read from an unmapped offset
`define LSMI_UNMAPPED_VALUE 8'h00

// misc event mask fields
`define LSMI_MISC_INT_TEMP_BIT 0
`define LSMI_MISC_BATTERY_BIT 1
`define LSMI_MISC_AIN_EIGHT_BIT 2
`define LSMI_MISC_THERMAL_ALARM_BIT 3
`define LSMI_MISC_AUTO_FAN_BIT 4
`define LSMI_MISC_CASE_INTRUSION_BIT 6
`define LSMI_MISC_PIN_SIXTEEN_BIT 7
// bit 5 is unused and reads back zero
`define LSMI_MISC_WRITABLE 8'hdf

// conversion result channel codes
`define LSMI_CH_REMOTE_ONE 5'h00
`define LSMI_CH_REMOTE_TWO 5'h01
`define LSMI_CH_AIN_BASE 5'h08
`define LSMI_CH_FAN_BASE 5'h10
`define LSMI_CH_BATTERY 5'h18
`define LSMI_CH_AIN_EIGHT 5'h19

// signed limits of the offset-corrected temperature
`define LSMI_TEMP_MAX 9'sh07f
`define LSMI_TEMP_MIN -9'sh080

`endif

// File: core/lsmi_temp_adj.v
`timescale 1ns/1ps
`include "lsmi_regs.vh"

module lsmi_temp_adj #(
    parameter DW = 8
) (
    input wire clk,
    input wire rst,
    input wire raw_valid,
    input wire [DW-1:0] raw_value,
    input wire [DW-1:0] offset,
    input wire [DW-1:0] high_limit,
    input wire [DW-1:0] low_limit,
    output wire [DW-1:0] value,
    output wire out_of_limit,
    output wire done
);

reg [DW-1:0] value_reg;
reg oor_reg;
reg done_reg;
reg signed [DW:0] sum;
reg signed [DW-1:0] clamped;

////////////////////////////////////////////////////////////////////////////////
// saturate instead of wrap: a wrapped hot reading would look cold
always @* begin
    sum = $signed({raw_value[DW-1], raw_value}) + $signed({offset[DW-1], offset});
    if (sum > `LSMI_TEMP_MAX) begin
        clamped = {1'b0, {(DW-1){1'b1}}};
    end else if (sum < `LSMI_TEMP_MIN) begin
        clamped = {1'b1, {(DW-1){1'b0}}};
    end else begin
        clamped = sum[DW-1:0];
    end
end

always @(posedge clk) begin
    if (rst) begin
        value_reg <= `LSMI_RESET_VALUE;
        oor_reg <= 1'b0;
        done_reg <= 1'b0;
    end else begin
        done_reg <= raw_valid;
        if (raw_valid) begin
            value_reg <= clamped; // [RQ9]
            oor_reg <= (clamped > $signed(high_limit)) || (clamped < $signed(low_limit)); // [RQ9]
        end
    end
end

assign value = value_reg;
assign out_of_limit = oor_reg;
assign done = done_reg;

endmodule

// File: core/lsmi_core.v
// Behaviour
// [RQ1] fan mask bits 0-7 block interrupts of tachometer channels 0-7
// [RQ2] misc mask bits 0,1,2 block internal temp, battery and analog eight
// [RQ3] misc mask bit 3 blocks thermal alarm engage/disengage interrupts
// [RQ4] misc mask bit 4 blocks automatic fan control on/off interrupts
// [RQ5] misc mask bit 6 blocks case intrusion interrupts
// [RQ6] misc mask bit 7 blocks general pin sixteen interrupts
// [RQ7] low pin mask bits 0-7 block general pins 0-7
// [RQ8] high pin mask bits 0-7 block general pins 8-15
// [RQ9] signed offset added to each internal temperature before store and compare
// [RQ10] latest corrected internal temperature readable, read only
// [RQ11] supply status bit is one when last conversion fell outside limits
// [RQ12] remote one status bit also set once on thermal alarm engage
// [RQ13] remote status bits also set once on thermal alarm disengage
// [RQ14] status bit 1 is remote two, or analog nine in voltage mode
// [RQ15] analog status bits 0-7 show analog inputs 0-7 out of limits
// [RQ16] fan status bits show tachometer above high limit, no low check
// [RQ17] masked channels keep updating status, only the interrupt is gated
// [RQ18] all masks, offset, value and status clear on reset; supply_irq_mask and analog_irq_mask are inputs and are not cleared here
`timescale 1ns/1ps
`include "lsmi_regs.vh"

module lsmi_core #(
    parameter DW = 8,
    parameter CW = 5
) (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [DW-1:0] reg_wdata,
    output wire [DW-1:0] reg_rdata,
    output wire reg_rvalid,
    input wire res_valid,
    input wire [CW-1:0] res_chan,
    input wire res_out_of_limit,
    input wire int_temp_valid,
    input wire [DW-1:0] int_temp_raw,
    input wire [DW-1:0] int_temp_high_limit,
    input wire [DW-1:0] int_temp_low_limit,
    input wire remote_diode_two_volt_mode,
    input wire [1:0] thermal_alarm_edge_remote,
    input wire [DW-1:0] supply_irq_mask,
    input wire [DW-1:0] analog_irq_mask,
    input wire thermal_alarm_status,
    input wire auto_fan_speed_control_status,
    input wire case_intrusion_status,
    input wire [16:0] general_pin_status,
    output wire irq,
    output wire [DW-1:0] int_temp_value,
    output wire int_temp_out_of_limit
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
        addr_hit = (addr == target);
    end
endfunction

function chan_hit;
    input [CW-1:0] chan;
    input [CW-1:0] base;
    input integer idx;
    begin
        chan_hit = (chan == base + idx[CW-1:0]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [DW-1:0] fan_irq_mask_reg;
reg [DW-1:0] misc_event_irq_mask_reg;
reg [DW-1:0] gpio_low_irq_mask_reg;
reg [DW-1:0] gpio_high_irq_mask_reg;
reg [DW-1:0] internal_temp_offset_reg;
reg [DW-1:0] voltage_remote_temp_status_reg;
reg [DW-1:0] analog_input_status_reg;
reg [DW-1:0] fan_status_reg;
reg battery_status_reg;
reg ain_eight_status_reg;
reg [DW-1:0] rdata_reg;
reg rvalid_reg;
reg irq_reg;

wire [DW-1:0] voltage_remote_temp_status_next;
wire [DW-1:0] analog_input_status_next;
wire [DW-1:0] fan_status_next;
wire [DW-1:0] temp_value;
wire temp_oor;

////////////////////////////////////////////////////////////////////////////////
// writable registers

always @(posedge clk) begin
    if (rst) begin
        fan_irq_mask_reg <= `LSMI_RESET_VALUE; // [RQ18]
        misc_event_irq_mask_reg <= `LSMI_RESET_VALUE;
        gpio_low_irq_mask_reg <= `LSMI_RESET_VALUE;
        gpio_high_irq_mask_reg <= `LSMI_RESET_VALUE;
        internal_temp_offset_reg <= `LSMI_RESET_VALUE;
    end else if (reg_wr) begin
        if (addr_hit(reg_addr, `LSMI_FAN_MASK_ADDR)) begin
            fan_irq_mask_reg <= reg_wdata;
        end
        if (addr_hit(reg_addr, `LSMI_MISC_MASK_ADDR)) begin
            misc_event_irq_mask_reg <= reg_wdata & `LSMI_MISC_WRITABLE;
        end
        if (addr_hit(reg_addr, `LSMI_GPIO_LO_MASK_ADDR)) begin
            gpio_low_irq_mask_reg <= reg_wdata;
        end
        if (addr_hit(reg_addr, `LSMI_GPIO_HI_MASK_ADDR)) begin
            gpio_high_irq_mask_reg <= reg_wdata;
        end
        if (addr_hit(reg_addr, `LSMI_TEMP_OFFSET_ADDR)) begin
            internal_temp_offset_reg <= reg_wdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// internal temperature: offset applied before store and limit compare

lsmi_temp_adj #(
    .DW(DW)
) u_temp_adj (
    .clk(clk),
    .rst(rst),
    .raw_valid(int_temp_valid),
    .raw_value(int_temp_raw),
    .offset(internal_temp_offset_reg),
    .high_limit(int_temp_high_limit),
    .low_limit(int_temp_low_limit),
    .value(temp_value),
    .out_of_limit(temp_oor),
    .done()
);

////////////////////////////////////////////////////////////////////////////////
// per-channel status, rewritten on every conversion result
// a thermal alarm edge in the same cycle as a result wins, so it is not lost

genvar i;
generate
    for (i = 0; i < DW; i = i + 1) begin : g_status
        wire volt_hit;
        wire ain_hit;
        wire fan_hit;
        wire ta_set;
        assign volt_hit = res_valid && chan_hit(res_chan, `LSMI_CH_REMOTE_ONE, i);
        assign ain_hit = res_valid && chan_hit(res_chan, `LSMI_CH_AIN_BASE, i);
        assign fan_hit = res_valid && chan_hit(res_chan, `LSMI_CH_FAN_BASE, i);
        if (i == 0) begin : g_remote_one
            assign ta_set = thermal_alarm_edge_remote[0]; // [RQ12] [RQ13]
        end else if (i == 1) begin : g_remote_two
            // analog nine mode has no thermal alarm
            assign ta_set = thermal_alarm_edge_remote[1] && !remote_diode_two_volt_mode; // [RQ14]
        end else begin : g_supply
            assign ta_set = 1'b0;
        end
        assign voltage_remote_temp_status_next[i] = ta_set ? 1'b1 :
            (volt_hit ? res_out_of_limit : voltage_remote_temp_status_reg[i]); // [RQ11] [RQ13]
        assign analog_input_status_next[i] = ain_hit ? res_out_of_limit :
            analog_input_status_reg[i]; // [RQ15]
        // fan comparator only flags above-high, so the input is taken as is
        assign fan_status_next[i] = fan_hit ? res_out_of_limit : fan_status_reg[i]; // [RQ16]
    end
endgenerate

always @(posedge clk) begin
    if (rst) begin
        voltage_remote_temp_status_reg <= `LSMI_RESET_VALUE; // [RQ18]
        analog_input_status_reg <= `LSMI_RESET_VALUE;
        fan_status_reg <= `LSMI_RESET_VALUE;
        battery_status_reg <= 1'b0;
        ain_eight_status_reg <= 1'b0;
    end else begin
        voltage_remote_temp_status_reg <= voltage_remote_temp_status_next;
        analog_input_status_reg <= analog_input_status_next;
        fan_status_reg <= fan_status_next;
        if (res_valid && res_chan == `LSMI_CH_BATTERY) begin
            battery_status_reg <= res_out_of_limit;
        end
        if (res_valid && res_chan == `LSMI_CH_AIN_EIGHT) begin
            ain_eight_status_reg <= res_out_of_limit;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt: masks gate only the combined output, status keeps updating

reg irq_next;
always @* begin
    irq_next = 1'b0;
    irq_next = irq_next | (|(voltage_remote_temp_status_reg & ~supply_irq_mask)); // [RQ17]
    irq_next = irq_next | (|(analog_input_status_reg & ~analog_irq_mask));
    irq_next = irq_next | (|(fan_status_reg & ~fan_irq_mask_reg)); // [RQ1]
    irq_next = irq_next | (temp_oor &
        ~misc_event_irq_mask_reg[`LSMI_MISC_INT_TEMP_BIT]); // [RQ2]
    irq_next = irq_next | (battery_status_reg &
        ~misc_event_irq_mask_reg[`LSMI_MISC_BATTERY_BIT]); // [RQ2]
    irq_next = irq_next | (ain_eight_status_reg &
        ~misc_event_irq_mask_reg[`LSMI_MISC_AIN_EIGHT_BIT]); // [RQ2]
    irq_next = irq_next | (thermal_alarm_status &
        ~misc_event_irq_mask_reg[`LSMI_MISC_THERMAL_ALARM_BIT]); // [RQ3]
    irq_next = irq_next | (auto_fan_speed_control_status &
        ~misc_event_irq_mask_reg[`LSMI_MISC_AUTO_FAN_BIT]); // [RQ4]
    irq_next = irq_next | (case_intrusion_status &
        ~misc_event_irq_mask_reg[`LSMI_MISC_CASE_INTRUSION_BIT]); // [RQ5]
    irq_next = irq_next | (general_pin_status[16] &
        ~misc_event_irq_mask_reg[`LSMI_MISC_PIN_SIXTEEN_BIT]); // [RQ6]
    irq_next = irq_next | (|(general_pin_status[7:0] & ~gpio_low_irq_mask_reg)); // [RQ7]
    irq_next = irq_next | (|(general_pin_status[15:8] & ~gpio_high_irq_mask_reg)); // [RQ8]
end

always @(posedge clk) begin
    if (rst) begin
        irq_reg <= 1'b0;
    end else begin
        irq_reg <= irq_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read port: data one cycle after the read strobe

reg [DW-1:0] rdata_next;
always @* begin
    case (reg_addr)
        `LSMI_FAN_MASK_ADDR: rdata_next = fan_irq_mask_reg;
        `LSMI_MISC_MASK_ADDR: rdata_next = misc_event_irq_mask_reg;
        `LSMI_GPIO_LO_MASK_ADDR: rdata_next = gpio_low_irq_mask_reg;
        `LSMI_GPIO_HI_MASK_ADDR: rdata_next = gpio_high_irq_mask_reg;
        `LSMI_TEMP_OFFSET_ADDR: rdata_next = internal_temp_offset_reg;
        `LSMI_TEMP_VALUE_ADDR: rdata_next = temp_value; // [RQ10]
        `LSMI_VOLT_STATUS_ADDR: rdata_next = voltage_remote_temp_status_reg; // [RQ11]
        `LSMI_AIN_STATUS_ADDR: rdata_next = analog_input_status_reg; // [RQ15]
        `LSMI_FAN_STATUS_ADDR: rdata_next = fan_status_reg; // [RQ16]
        default: rdata_next = `LSMI_UNMAPPED_VALUE;
    endcase
end

always @(posedge clk) begin
    if (rst) begin
        rdata_reg <= `LSMI_RESET_VALUE;
        rvalid_reg <= 1'b0;
    end else begin
        rvalid_reg <= reg_rd;
        if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign reg_rdata = rdata_reg;
assign reg_rvalid = rvalid_reg;
assign irq = irq_reg;
assign int_temp_value = temp_value;
assign int_temp_out_of_limit = temp_oor;

endmodule

// File: dv/lsmi_props.sv
`timescale 1ns/1ps
module lsmi_props (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire int_temp_valid,
    input wire [7:0] int_temp_value,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rv; reg_rd |=> reg_rvalid; endproperty
    property p_norv; !reg_rd |=> !reg_rvalid; endproperty
    // read data is a register, so it must not drift between reads
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    property p_rst; $fell(rst) |-> !irq && !reg_rvalid && int_temp_value == 8'h00; endproperty
    property p_temp; reg_rd && reg_addr == 8'h1f |=> reg_rdata == $past(int_temp_value);
    endproperty
    property p_unmap; reg_rd && (reg_addr < 8'h1a || reg_addr > 8'h22) |=> reg_rdata == 8'h00;
    endproperty
    property p_bit5; reg_rd && reg_addr == 8'h1b |=> !reg_rdata[5]; endproperty
    property p_tstable; !int_temp_valid |=> $stable(int_temp_value); endproperty
    a_rv: assert property (p_rv)
        else $error("read strobe without read valid");
    a_norv: assert property (p_norv)
        else $error("read valid without read strobe");
    a_hold: assert property (p_hold)
        else $error("read data changed without a read");
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
    a_temp: assert property (p_temp)
        else $error("temperature read differs from value port");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    a_bit5: assert property (p_bit5)
        else $error("unused misc mask bit reads one");
    a_tstable: assert property (p_tstable)
        else $error("temperature changed without a sample");
    c_irq: cover property (irq);
    c_temp: cover property (int_temp_valid);
    c_fan: cover property (reg_rd && reg_addr == 8'h22);
endmodule

bind lsmi_core lsmi_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .int_temp_valid(int_temp_valid), .int_temp_value(int_temp_value), .irq(irq));

// File: dv/lsmi_conv_src.sv
`timescale 1ns/1ps
module lsmi_conv_src (
    input wire clk,
    output logic res_valid,
    output logic [4:0] res_chan,
    output logic res_out_of_limit
);
    initial begin
        res_valid = 1'b0;
        res_chan = 5'h1f;
        res_out_of_limit = 1'b0;
    end
    // idle fields show the inverse so a stale value is never taken for a result
    task automatic send(input logic [4:0] ch, input logic oor, input int gap);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        res_valid = 1'b1;
        res_chan = ch;
        res_out_of_limit = oor;
        @(negedge clk);
        res_valid = 1'b0;
        res_chan = ~ch;
        res_out_of_limit = ~oor;
    endtask
endmodule

// File: dv/lsmi_core_bench.sv
`timescale 1ns/1ps
module lsmi_core_bench;
    logic clk, rst, reg_wr, reg_rd, int_temp_valid, remote_diode_two_volt_mode, irq;
    logic thermal_alarm_status, auto_fan_speed_control_status, case_intrusion_status;
    logic res_valid, res_out_of_limit, reg_rvalid, int_temp_out_of_limit;
    logic [4:0] res_chan;
    logic [1:0] thermal_alarm_edge_remote;
    logic [16:0] general_pin_status;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, int_temp_raw, int_temp_value, v, b, e;
    logic [7:0] int_temp_high_limit, int_temp_low_limit, supply_irq_mask, analog_irq_mask;
    logic [7:0] exp_q[$];
    logic [8:0] s;
    logic [2:0] mbit [0:3] = '{3'h7, 3'h3, 3'h4, 3'h6};
    int bad_count = 0;
    int n_compared = 0;
    int i;
    lsmi_core u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .res_valid(res_valid), .res_chan(res_chan),
        .res_out_of_limit(res_out_of_limit), .int_temp_valid(int_temp_valid),
        .int_temp_raw(int_temp_raw), .int_temp_high_limit(int_temp_high_limit),
        .int_temp_low_limit(int_temp_low_limit),
        .remote_diode_two_volt_mode(remote_diode_two_volt_mode),
        .thermal_alarm_edge_remote(thermal_alarm_edge_remote),
        .supply_irq_mask(supply_irq_mask), .analog_irq_mask(analog_irq_mask),
        .thermal_alarm_status(thermal_alarm_status),
        .auto_fan_speed_control_status(auto_fan_speed_control_status),
        .case_intrusion_status(case_intrusion_status),
        .general_pin_status(general_pin_status), .irq(irq),
        .int_temp_value(int_temp_value), .int_temp_out_of_limit(int_temp_out_of_limit));
    lsmi_conv_src u_src (.clk(clk), .res_valid(res_valid), .res_chan(res_chan),
        .res_out_of_limit(res_out_of_limit));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_compared++;
        if (got !== ex) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // strobes drop and a full cycle passes so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(ex);
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
    endtask
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end
    task automatic chk_irq(input logic ex);
        repeat (2) @(negedge clk);
        chk("irq", {7'h00, ex}, {7'h00, irq});
    endtask
    task automatic setm(input logic [4:0] ch, input logic [7:0] m);
        if (ch < 5'h08) supply_irq_mask = m;
        else if (ch < 5'h10) analog_irq_mask = m;
        else if (ch < 5'h18) wr(8'h1a, m);
        else wr(8'h1b, m << 1);
    endtask
    task automatic tpulse(input logic [7:0] r);
        int_temp_valid = 1'b1;
        int_temp_raw = r;
        @(negedge clk);
        int_temp_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h157d));
        rst = 1'b1;
        {reg_wr, reg_rd, int_temp_valid, remote_diode_two_volt_mode} = 4'h0;
        {case_intrusion_status, auto_fan_speed_control_status, thermal_alarm_status} = 3'h0;
        {general_pin_status, thermal_alarm_edge_remote} = 19'h0;
        {reg_addr, reg_wdata, int_temp_raw, supply_irq_mask, analog_irq_mask} = 40'h0;
        int_temp_high_limit = 8'h7f;
        int_temp_low_limit = 8'h80;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        for (i = 0; i < 9; i++) rd(8'(8'h1a + i), 8'h00);
        for (i = 0; i < 5; i++) begin
            v = 8'($urandom);
            wr(8'(8'h1a + i), v);
            rd(8'(8'h1a + i), (i == 1) ? (v & 8'hdf) : v);
            wr(8'(8'h1a + i), 8'h00);
        end
        wr(8'h1f, 8'hff);
        rd(8'h1f, 8'h00);
        // limit channels 2 to 25: status for 2 to 23, unmasked irq, masked irq with status kept
        for (i = 2; i < 26; i++) begin
            b = 8'h01 << i[2:0];
            u_src.send(5'(i), 1'b1, $urandom_range(2));
            rd(8'(8'h20 + i / 8), (i < 24) ? b : 8'h00);
            setm(5'(i), 8'h00);
            chk_irq(1'b1);
            setm(5'(i), b);
            chk_irq(1'b0);
            rd(8'(8'h20 + i / 8), (i < 24) ? b : 8'h00);
            u_src.send(5'(i), 1'b0, 0);
        end
        for (i = 0; i < 2; i++) begin
            remote_diode_two_volt_mode = i[0];
            thermal_alarm_edge_remote = 2'b11;
            @(negedge clk);
            thermal_alarm_edge_remote = 2'b00;
            rd(8'h20, i ? 8'h01 : 8'h03);
            u_src.send(5'h00, 1'b0, 0);
            u_src.send(5'h01, 1'b1, 1);
            rd(8'h20, 8'h02);
            u_src.send(5'h01, 1'b0, 0);
        end
        for (i = 0; i < 20; i++) begin
            {case_intrusion_status, auto_fan_speed_control_status, thermal_alarm_status,
                general_pin_status} = 20'h1 << i;
            v = (i < 8) ? 8'h1c : (i < 16) ? 8'h1d : 8'h1b;
            b = 8'h01 << ((i < 16) ? i[2:0] : mbit[i - 16]);
            chk_irq(1'b1);
            wr(v, b);
            chk_irq(1'b0);
            wr(v, 8'h00);
        end
        {case_intrusion_status, general_pin_status} = 18'h0;
        for (i = 0; i < 6; i++) begin
            v = (i < 2) ? 8'(8'h7f + i) : 8'($urandom);
            b = (i < 2) ? 8'(8'h7f + i) : 8'($urandom);
            s = {v[7], v} + {b[7], b};
            // the sum saturates instead of wrapping at the signed limits
            e = (s[8] != s[7]) ? {s[8], {7{~s[8]}}} : s[7:0];
            wr(8'h1e, b);
            tpulse(v);
            chk("int_temp_value", e, int_temp_value);
            chk("int_temp_out_of_limit", 8'h00, {7'h00, int_temp_out_of_limit});
            rd(8'h1f, e);
        end
        wr(8'h1e, 8'h00);
        int_temp_high_limit = 8'h80;
        tpulse(8'h00);
        chk("int_temp_out_of_limit", 8'h01, {7'h00, int_temp_out_of_limit});
        chk_irq(1'b1);
        wr(8'h1b, 8'h01);
        chk_irq(1'b0);
        // low limit side of the signed compare
        int_temp_high_limit = 8'h7f;
        int_temp_low_limit = 8'h01;
        tpulse(8'h00);
        chk("int_temp_out_of_limit", 8'h01, {7'h00, int_temp_out_of_limit});
        complete_run;
    end
endmodule
